// File: design/pll_clk_pkg.sv
/*
  package for the pll divider and base clock select block: register offsets,
  field positions, reset values and shared types.
  assumes an 8-bit register port; registers sit at their own index addresses.
*/
package pll_clk_pkg;

  // register indices on the plain register port
  localparam logic [2:0] ADDR_CONTROL   = 3'h0;
  localparam logic [2:0] ADDR_BANDWIDTH = 3'h1;
  localparam logic [2:0] ADDR_MULT_HIGH = 3'h2;
  localparam logic [2:0] ADDR_MULT_LOW  = 3'h3;
  localparam logic [2:0] ADDR_RANGE     = 3'h4;
  localparam logic [2:0] ADDR_REF_DIV   = 3'h5;
  localparam logic [2:0] ADDR_STATUS    = 3'h6;

  // control register field positions
  localparam int CTL_VPR_LSB = 0;
  localparam int CTL_PRE_LSB = 2;
  localparam int CTL_BCS_BIT = 4;
  localparam int CTL_PON_BIT = 5;
  // bandwidth register field positions
  localparam int BW_ACQ_BIT  = 6;
  localparam int BW_AUTO_BIT = 7;

  // reset values
  localparam logic [1:0]  RST_PRESCALE  = 2'h0;
  localparam logic [1:0]  RST_RANGE_EXP = 2'h0;
  localparam logic        RST_PLL_ON    = 1'b1;
  localparam logic        RST_BCS       = 1'b0;
  localparam logic        RST_AUTO      = 1'b0;
  localparam logic        RST_ACQ       = 1'b0;
  localparam logic [3:0]  RST_MULT_HIGH = 4'h0;
  localparam logic [7:0]  RST_MULT_LOW  = 8'h40;
  localparam logic [7:0]  RST_RANGE     = 8'h40;
  localparam logic [3:0]  RST_REF_DIV   = 4'h1;

  // synchroniser depth per clock during a switch
  localparam int SYNC_STAGES = 3;
  // nominal range step in hertz, center = l * 2**e * step
  localparam int NOM_STEP_HZ = 38400;

  // settings seen by the pll dividers
  typedef struct packed {
    logic [1:0]  prescale_exp;
    logic [1:0]  range_exp;
    logic [11:0] feedback_mult;
    logic [7:0]  linear_range;
    logic [3:0]  ref_div;
    logic        pll_enable;
  } pll_cfg_t;

endpackage

// File: design/glitch_free_mux.sv
/*
  glitch-free two-source clock switch, one synchroniser chain per source.
  assumes both source clocks are sampled here as data by the system clock.
*/
`timescale 1ns/10ps
module glitch_free_mux (
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  input  wire logic sel_vco_i,
  input  wire logic crystal_clock_i,
  input  wire logic vco_clock_i,
  output logic      mux_clk_o,
  output logic      busy_o
);
  logic [1:0] src_s1_q;
  logic [1:0] src_s2_q;
  logic [1:0] src_prev_q;
  logic [1:0] src_fall;
  logic [1:0] en_q;
  logic [1:0] want;
  logic [1:0] cnt_q [2];
  logic       out_q;

  assign want = {sel_vco_i, ~sel_vco_i};

  // per-source falling edge detect and enable sequencer
  for (genvar g = 0; g < 2; g++) begin : g_src
    always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
        src_s1_q[g]   <= 1'b0;
        src_s2_q[g]   <= 1'b0;
        src_prev_q[g] <= 1'b0;
      end else begin
        src_s1_q[g]   <= (g == 0) ? crystal_clock_i : vco_clock_i;
        src_s2_q[g]   <= src_s1_q[g];
        src_prev_q[g] <= src_s2_q[g];
      end
    end
    assign src_fall[g] = src_prev_q[g] & ~src_s2_q[g];

    always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
        en_q[g]  <= (g == 0);
        cnt_q[g] <= 2'h0;
      end else if (want[g] != en_q[g]) begin
        if (want[g] && en_q[1-g]) begin
          cnt_q[g] <= 2'h0;
        end else if (src_fall[g]) begin
          if (cnt_q[g] == 2'(pll_clk_pkg::SYNC_STAGES - 1)) begin
            en_q[g]  <= want[g];
            cnt_q[g] <= 2'h0;
          end else begin
            cnt_q[g] <= cnt_q[g] + 2'h1;
          end
        end
      end else begin
        cnt_q[g] <= 2'h0;
      end
    end
  end

  // output holds its level while neither source is enabled
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      out_q <= 1'b0;
    end else if (en_q[0]) begin
      out_q <= src_s2_q[0];
    end else if (en_q[1]) begin
      out_q <= src_s2_q[1];
    end
  end

  assign mux_clk_o = out_q;
  assign busy_o    = (en_q != want);
endmodule // glitch_free_mux

// File: design/pll_clock_ctrl.sv
/*
  pll divider programming and base clock selection for the clock generator.
  assumes crystal and vco clocks arrive as slow level signals sampled on
  clock_i, and that software uses the plain register port.
*/
`timescale 1ns/10ps
module pll_clock_ctrl (
  input  wire logic               clock_i,
  input  wire logic               sys_rst_i,
  input  wire logic [2:0]         reg_addr_i,
  input  wire logic [7:0]         reg_wdata_i,
  input  wire logic               reg_write_i,
  input  wire logic               reg_read_i,
  output logic      [7:0]         reg_rdata_o,
  input  wire logic               crystal_clock_i,
  input  wire logic               vco_clock_i,
  input  wire logic               pll_lock_i,
  output pll_clk_pkg::pll_cfg_t   pll_cfg_o,
  output logic                    filter_track_o,
  output logic                    lock_indicator_o,
  output logic                    irq_allowed_o,
  output logic                    base_clock_out_o
);
  logic [1:0]  prescale_q;
  logic [1:0]  range_exp_q;
  logic        base_clock_select_q;
  logic        pll_power_on_q;
  logic        auto_q;
  logic        acq_q;
  logic [3:0]  mult_high_q;
  logic [7:0]  mult_low_q;
  logic [7:0]  range_q;
  logic [3:0]  ref_div_q;
  logic [7:0]  rdata_q;
  logic        lock_s1_q;
  logic        lock_s2_q;
  logic        mux_clk;
  logic        switch_busy;
  logic        base_clock_out_q;
  logic        wr_ctl;
  logic        range_zero;
  logic [11:0] n_raw;
  pll_clk_pkg::pll_cfg_t cfg_d;
  pll_clk_pkg::pll_cfg_t cfg_q;

  assign wr_ctl     = reg_write_i && (reg_addr_i == pll_clk_pkg::ADDR_CONTROL);
  assign range_zero = (range_q == 8'h00);

  // control register: power and select interlocks
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pll_power_on_q      <= pll_clk_pkg::RST_PLL_ON;
      base_clock_select_q <= pll_clk_pkg::RST_BCS;
    end else begin
      if (range_zero) begin
        base_clock_select_q <= 1'b0;
      end else if (wr_ctl) begin
        if (reg_wdata_i[pll_clk_pkg::CTL_BCS_BIT]) begin
          if (pll_power_on_q) begin
            base_clock_select_q <= 1'b1;
          end
        end else begin
          base_clock_select_q <= 1'b0;
        end
      end
      if (wr_ctl) begin
        if (reg_wdata_i[pll_clk_pkg::CTL_PON_BIT] || !base_clock_select_q) begin
          pll_power_on_q <= reg_wdata_i[pll_clk_pkg::CTL_PON_BIT];
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      prescale_q  <= pll_clk_pkg::RST_PRESCALE;
      range_exp_q <= pll_clk_pkg::RST_RANGE_EXP;
    end else if (wr_ctl && !pll_power_on_q) begin
      prescale_q  <= reg_wdata_i[pll_clk_pkg::CTL_PRE_LSB +: 2];
      range_exp_q <= reg_wdata_i[pll_clk_pkg::CTL_VPR_LSB +: 2];
    end
  end

  // bandwidth mode register
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      auto_q <= pll_clk_pkg::RST_AUTO;
      acq_q  <= pll_clk_pkg::RST_ACQ;
    end else if (reg_write_i && (reg_addr_i == pll_clk_pkg::ADDR_BANDWIDTH)) begin
      auto_q <= reg_wdata_i[pll_clk_pkg::BW_AUTO_BIT];
      acq_q  <= reg_wdata_i[pll_clk_pkg::BW_ACQ_BIT];
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      mult_high_q <= pll_clk_pkg::RST_MULT_HIGH;
      mult_low_q  <= pll_clk_pkg::RST_MULT_LOW;
      range_q     <= pll_clk_pkg::RST_RANGE;
      ref_div_q   <= pll_clk_pkg::RST_REF_DIV;
    end else if (reg_write_i) begin
      case (reg_addr_i)
        pll_clk_pkg::ADDR_MULT_HIGH: mult_high_q <= reg_wdata_i[3:0];
        pll_clk_pkg::ADDR_MULT_LOW:  mult_low_q  <= reg_wdata_i;
        pll_clk_pkg::ADDR_RANGE:     range_q     <= reg_wdata_i;
        pll_clk_pkg::ADDR_REF_DIV:   ref_div_q   <= reg_wdata_i[3:0];
        default: ;
      endcase
    end
  end

  // lock pin from the analog side is asynchronous
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      lock_s1_q <= 1'b0;
      lock_s2_q <= 1'b0;
    end else begin
      lock_s1_q <= pll_lock_i;
      lock_s2_q <= lock_s2_q ^ (lock_s1_q ^ lock_s2_q);
    end
  end

  // settings handed to the dividers
  assign n_raw = {mult_high_q, mult_low_q};
  always_comb begin
    cfg_d = '0;
    // dividers set vco = ref * 2^p * n / r
    cfg_d.prescale_exp  = prescale_q;
    cfg_d.range_exp     = range_exp_q;
    cfg_d.linear_range  = range_q;
    cfg_d.feedback_mult = (n_raw == 12'h000) ? 12'h001 : n_raw;
    cfg_d.ref_div       = (ref_div_q == 4'h0) ? 4'h1 : ref_div_q;
    cfg_d.pll_enable    = pll_power_on_q && !range_zero;
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cfg_q <= '0;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  glitch_free_mux u_switch (
    .clock_i         (clock_i),
    .sys_rst_i       (sys_rst_i),
    .sel_vco_i       (base_clock_select_q),
    .crystal_clock_i (crystal_clock_i),
    .vco_clock_i     (vco_clock_i),
    .mux_clk_o       (mux_clk),
    .busy_o          (switch_busy)
  );

  // divide by two on rising edge of switch output
  logic mux_prev_q;
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      mux_prev_q       <= 1'b0;
      base_clock_out_q <= 1'b0;
    end else begin
      mux_prev_q <= mux_clk;
      if (mux_clk && !mux_prev_q) begin
        base_clock_out_q <= ~base_clock_out_q;
      end
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rdata_q <= 8'h00;
    end else if (reg_read_i) begin
      case (reg_addr_i)
        pll_clk_pkg::ADDR_CONTROL:   rdata_q <= {2'h0, pll_power_on_q, base_clock_select_q,
                                                 prescale_q, range_exp_q};
        // lock reads clear in manual mode
        pll_clk_pkg::ADDR_BANDWIDTH: rdata_q <= {auto_q, acq_q, lock_s2_q && auto_q, 5'h00};
        pll_clk_pkg::ADDR_MULT_HIGH: rdata_q <= {4'h0, mult_high_q};
        pll_clk_pkg::ADDR_MULT_LOW:  rdata_q <= mult_low_q;
        pll_clk_pkg::ADDR_RANGE:     rdata_q <= range_q;
        pll_clk_pkg::ADDR_REF_DIV:   rdata_q <= {4'h0, ref_div_q};
        pll_clk_pkg::ADDR_STATUS:    rdata_q <= {7'h00, switch_busy};
        default:                     rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata_o      = rdata_q;
  assign pll_cfg_o        = cfg_q;
  // manual mode: acq bit steers filter; auto: tracking follows lock
  assign filter_track_o   = auto_q ? lock_s2_q : acq_q;
  // manual mode gates lock and interrupts
  assign lock_indicator_o = auto_q && lock_s2_q;
  assign irq_allowed_o    = auto_q;
  assign base_clock_out_o = base_clock_out_q;
endmodule // pll_clock_ctrl

// File: bench/pll_clock_ctrl_asserts.sv
/* checker for pll_clock_ctrl port behaviour.
   assumes the single clock_i domain and sync reset sys_rst_i. */
`timescale 1ns/10ps
module pll_clock_ctrl_asserts (
  input wire logic                  clock_i,
  input wire logic                  sys_rst_i,
  input wire logic [2:0]            reg_addr_i,
  input wire logic [7:0]            reg_wdata_i,
  input wire logic                  reg_write_i,
  input wire logic                  reg_read_i,
  input wire logic [7:0]            reg_rdata_o,
  input wire logic                  crystal_clock_i,
  input wire logic                  vco_clock_i,
  input wire logic                  pll_lock_i,
  input wire pll_clk_pkg::pll_cfg_t pll_cfg_o,
  input wire logic                  filter_track_o,
  input wire logic                  lock_indicator_o,
  input wire logic                  irq_allowed_o,
  input wire logic                  base_clock_out_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_ctl_rd;
    reg_read_i && reg_addr_i == pll_clk_pkg::ADDR_CONTROL;
  endsequence
  sequence s_l_zero;
    (pll_cfg_o.linear_range == 8'h00)[*2];
  endsequence
  sequence s_ctl_wr;
    reg_write_i && reg_addr_i == pll_clk_pkg::ADDR_CONTROL;
  endsequence
  a_rdata_idle_zero: assert property (!reg_read_i |=> reg_rdata_o == 8'h00)
    else $error("read data not zero outside read cycle");
  a_manual_no_lock: assert property (!irq_allowed_o |-> !lock_indicator_o)
    else $error("lock indicator active in manual mode");
  a_ref_div_one: assert property (!$past(sys_rst_i) |-> pll_cfg_o.ref_div != 4'h0)
    else $error("reference divider shown as zero");
  a_mult_not_zero: assert property (!$past(sys_rst_i) |-> pll_cfg_o.feedback_mult != 12'h000)
    else $error("feedback multiplier shown as zero");
  a_l_zero_off: assert property (pll_cfg_o.linear_range == 8'h00 |-> !pll_cfg_o.pll_enable)
    else $error("pll enabled with zero linear range");
  a_l_zero_select: assert property (s_l_zero ##0 s_ctl_rd |=> !reg_rdata_o[4])
    else $error("vco selected with zero linear range");
  a_prescale_locked: assert property (pll_cfg_o.pll_enable && !$past(reg_write_i) ##0 s_ctl_wr
    |=> ##1 $stable(pll_cfg_o.prescale_exp) && $stable(pll_cfg_o.range_exp))
    else $error("prescale or range written while pll on");
  a_base_half_rate: assert property ($changed(base_clock_out_o) |=> $stable(base_clock_out_o))
    else $error("base clock toggled on consecutive cycles");
endmodule // pll_clock_ctrl_asserts
bind pll_clock_ctrl pll_clock_ctrl_asserts u_chk (.clock_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i,
  .reg_write_i, .reg_read_i, .reg_rdata_o, .crystal_clock_i, .vco_clock_i, .pll_lock_i, .pll_cfg_o,
  .filter_track_o, .lock_indicator_o, .irq_allowed_o, .base_clock_out_o);

// File: bench/pll_clock_ctrl_tb.sv
/* self-checking bench for pll_clock_ctrl.
   assumes the register port contract; source clocks are slow bench toggles. */
`timescale 1ns/10ps
module pll_clock_ctrl_tb;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, xc = 1'b0, vc = 1'b0, lk = 1'b0, pend = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wd = 8'h00, rdata, r;
  logic [11:0] g;
  // half periods of the bench source clocks, in system clock cycles
  localparam int XC_HALF = 5;
  localparam int VC_HALF = 3;
  logic track, lock_o, irq_o, base;
  pll_clk_pkg::pll_cfg_t cfg;
  logic [7:0] expq[$];
  int n_fail = 0, n_compared = 0, cyc = 0, seed = 31523;
  always #2 clk = ~clk;
  pll_clock_ctrl dut (.clock_i(clk), .sys_rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_write_i(wr), .reg_read_i(rd), .reg_rdata_o(rdata), .crystal_clock_i(xc), .vco_clock_i(vc),
    .pll_lock_i(lk), .pll_cfg_o(cfg), .filter_track_o(track), .lock_indicator_o(lock_o),
    .irq_allowed_o(irq_o), .base_clock_out_o(base));
  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one idle edge after each strobe, so a following call never re-raises it in the same step
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    addr <= a; wd <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [2:0] a, input logic [7:0] e);
    expq.push_back(e);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask
  // cycles between two toggles of the base clock; a dead output is caught by the timeout
  task automatic base_gap(output logic [11:0] n);
    logic b;
    b = base;
    n = 12'h000;
    while (base === b) @(posedge clk);
    b = base;
    while (base === b) begin
      @(posedge clk);
      n = n + 12'h001;
    end
  endtask
  // slow, unrelated source clocks so the switch sees real edges
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc % XC_HALF == 0) xc <= ~xc;
    if (cyc % VC_HALF == 0) vc <= ~vc;
    if (cyc > 3000) begin
      n_fail++;
      end_of_test();
    end
  end
  // read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (pend) chk("rdata", rdata, expq.pop_front());
    pend <= rd;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    lk <= 1'b1;
    @(posedge clk);
    rreg(pll_clk_pkg::ADDR_CONTROL, 8'h20);
    rreg(pll_clk_pkg::ADDR_MULT_LOW, 8'h40);
    rreg(pll_clk_pkg::ADDR_RANGE, 8'h40);
    rreg(3'h7, 8'h00);
    chk("feedback", cfg.feedback_mult, 12'h040);
    chk("irq", irq_o, 1'b0);
    chk("lock", lock_o, 1'b0);
    base_gap(g);
    chk("crystal_gap", g, 12'(2 * XC_HALF));
    wreg(pll_clk_pkg::ADDR_CONTROL, 8'h2E);
    rreg(pll_clk_pkg::ADDR_CONTROL, 8'h20);
    wreg(pll_clk_pkg::ADDR_BANDWIDTH, 8'h40);
    chk("track", track, 1'b1);
    rreg(pll_clk_pkg::ADDR_BANDWIDTH, 8'h40);
    // settle time in tracking before the vco is chosen
    repeat (10) @(posedge clk);
    wreg(pll_clk_pkg::ADDR_CONTROL, 8'h30);
    rreg(pll_clk_pkg::ADDR_CONTROL, 8'h30);
    rreg(pll_clk_pkg::ADDR_STATUS, 8'h01);
    repeat (80) @(posedge clk);
    rreg(pll_clk_pkg::ADDR_STATUS, 8'h00);
    base_gap(g);
    chk("vco_gap", g, 12'(2 * VC_HALF));
    wreg(pll_clk_pkg::ADDR_CONTROL, 8'h00);
    rreg(pll_clk_pkg::ADDR_CONTROL, 8'h20);
    wreg(pll_clk_pkg::ADDR_CONTROL, 8'h00);
    wreg(pll_clk_pkg::ADDR_CONTROL, 8'h3E);
    rreg(pll_clk_pkg::ADDR_CONTROL, 8'h2E);
    wreg(pll_clk_pkg::ADDR_REF_DIV, 8'h00);
    wreg(pll_clk_pkg::ADDR_MULT_HIGH, 8'h00);
    wreg(pll_clk_pkg::ADDR_MULT_LOW, 8'h00);
    repeat (2) @(posedge clk);
    chk("ref_div", cfg.ref_div, 12'h001);
    chk("feedback", cfg.feedback_mult, 12'h001);
    chk("prescale", cfg.prescale_exp, 12'h003);
    wreg(pll_clk_pkg::ADDR_CONTROL, 8'h3E);
    wreg(pll_clk_pkg::ADDR_RANGE, 8'h00);
    rreg(pll_clk_pkg::ADDR_CONTROL, 8'h2E);
    chk("enable", cfg.pll_enable, 1'b0);
    wreg(pll_clk_pkg::ADDR_CONTROL, 8'h3E);
    rreg(pll_clk_pkg::ADDR_CONTROL, 8'h2E);
    repeat (4) begin
      r = 8'($random(seed));
      r[0] = 1'b1;
      wreg(pll_clk_pkg::ADDR_MULT_HIGH, {4'h0, r[7:4]});
      wreg(pll_clk_pkg::ADDR_MULT_LOW, r);
      wreg(pll_clk_pkg::ADDR_RANGE, r);
      rreg(pll_clk_pkg::ADDR_RANGE, r);
      @(posedge clk);
      chk("feedback", cfg.feedback_mult, {r[7:4], r});
      chk("range", cfg.linear_range, {4'h0, r});
    end
    wreg(pll_clk_pkg::ADDR_BANDWIDTH, 8'h80);
    repeat (4) @(posedge clk);
    chk("irq", irq_o, 1'b1);
    chk("lock", lock_o, 1'b1);
    rreg(pll_clk_pkg::ADDR_BANDWIDTH, 8'hA0);
    repeat (3) @(posedge clk);
    end_of_test();
  end
endmodule // pll_clock_ctrl_tb
